// >>> hdl/vcf_frame_tx.sv
`timescale 1ns/1ns
// shifts a 40-bit frame out, bit 0 first, over a gated divided clock
module vcf_frame_tx #(
    parameter int BITS = vcf_pkg::FRAME_BITS,
    parameter int DIV  = vcf_pkg::OSC_DIV
) (
    input  wire logic            clk,
    input  wire logic            rstn,
    input  wire logic            hold,
    input  wire logic            start,
    input  wire logic [BITS-1:0] frame,
    output logic                 busy,
    output logic                 sclk,
    output logic                 sdata
);
    // the divider needs a low and a high half, the frame at least two bits
    if (DIV < 2 || BITS < 2)
    begin : g_param_check
        $error("vcf_frame_tx: DIV and BITS must be at least 2");
    end

    localparam int CW = $clog2(DIV + 1);
    localparam int BW = $clog2(BITS + 1);

    vcf_pkg::vcf_state_t state;
    vcf_pkg::vcf_state_t next_state;
    logic [BITS-1:0]     shreg;
    logic [CW-1:0]       div_cnt;
    logic [BW-1:0]       bit_cnt;

    wire half_tick = (div_cnt == CW'(DIV / 2 - 1));
    wire full_tick = (div_cnt == CW'(DIV - 1));
    wire last_bit  = (bit_cnt == BW'(BITS - 1));

    ////////////////////////////////////////////////////////////////////////////////
    // low half: data set up; high half: rising edge samples the stable bit
    always_comb
    begin
        next_state = state;
        unique case (state)
            vcf_pkg::VCF_IDLE:  if (start) next_state = vcf_pkg::VCF_LOW;
            vcf_pkg::VCF_LOW:   if (half_tick) next_state = vcf_pkg::VCF_HIGH;
            vcf_pkg::VCF_HIGH:  if (full_tick)
                                    next_state = last_bit ? vcf_pkg::VCF_IDLE : vcf_pkg::VCF_LOW;
            vcf_pkg::VCF_RESET: next_state = vcf_pkg::VCF_IDLE;
        endcase
        if (hold)
            next_state = vcf_pkg::VCF_RESET;
    end

    assign busy = (state == vcf_pkg::VCF_LOW) || (state == vcf_pkg::VCF_HIGH);

    ////////////////////////////////////////////////////////////////////////////////
    // oscillator runs only while a frame is in flight
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state   <= vcf_pkg::VCF_IDLE;
            div_cnt <= '0;
            bit_cnt <= '0;
            shreg   <= '0;
            sclk    <= 1'b0;
            sdata   <= 1'b0;
        end
        else
        begin
            state   <= next_state;
            div_cnt <= (busy && !full_tick && !hold) ? div_cnt + 1'b1 : '0;
            sclk    <= (next_state == vcf_pkg::VCF_HIGH);
            if (state == vcf_pkg::VCF_IDLE && start && !hold)
            begin
                shreg   <= frame >> 1;
                sdata   <= frame[0];
                bit_cnt <= '0;
            end
            else if (state == vcf_pkg::VCF_HIGH && full_tick && !last_bit && !hold)
            begin
                sdata   <= shreg[0];
                shreg   <= shreg >> 1;
                bit_cnt <= bit_cnt + 1'b1;
            end
            else if (next_state != vcf_pkg::VCF_LOW && next_state != vcf_pkg::VCF_HIGH)
                sdata   <= 1'b0;
        end
    end
endmodule : vcf_frame_tx

// >>> hdl/vcf_pkg.sv
package vcf_pkg;
    // register addresses on the serial configuration port
    localparam logic [7:0]  ADDR_SOFT_RESET   = 8'h00;
    localparam logic [7:0]  ADDR_SECTION_RST  = 8'h03;
    localparam logic [7:0]  ADDR_FRAME_LOW    = 8'h16;
    localparam logic [7:0]  ADDR_FRAME_MID    = 8'h17;
    localparam logic [7:0]  ADDR_FRAME_HIGH   = 8'h18;
    localparam logic [7:0]  ADDR_GAIN_A       = 8'h2A;
    localparam logic [7:0]  ADDR_GAIN_B       = 8'h2B;
    localparam logic [7:0]  ADDR_OUT_FORMAT   = 8'h46;
    // field positions
    localparam int          SOFT_RESET_BIT    = 0;
    localparam int          SECTION_HOLD_BIT  = 5;
    localparam int          FMT_BTC_BIT       = 2;
    localparam int          FMT_MSB_FIRST_BIT = 3;
    localparam int          FMT_SDR_BIT       = 4;
    // reset values of the mirrored words; low word has bit 5 set, bits 1:0 forced
    localparam logic [15:0] FRAME_LOW_RESET   = 16'h0020;
    localparam logic [15:0] FRAME_LOW_FORCE   = 16'h0003;
    localparam logic [15:0] FRAME_MID_RESET   = 16'h0000;
    localparam logic [7:0]  FRAME_HIGH_RESET  = 8'h00;
    localparam logic [15:0] GAIN_RESET        = 16'h0000;
    localparam logic [15:0] FORMAT_RESET      = 16'h0000;
    // serial word layout: 8 address bits then 16 data bits
    localparam int          WORD_BITS         = 24;
    localparam int          FRAME_BITS        = 40;
    // timing
    localparam int          CLK_HZ            = 25_000_000;
    localparam int          OSC_HZ            = 6_000_000;
    // longest period at 6 MHz rounds down to whole cycles (at least two)
    localparam int          OSC_DIV           = (CLK_HZ / OSC_HZ) < 2 ? 2 : (CLK_HZ / OSC_HZ);
    localparam int          RST_PULSE_NS      = 10;
    localparam int          CLK_PERIOD_NS     = 40;
    // least pulse width rounds up, never below one cycle
    localparam int          RST_PULSE_CYC     =
        (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // frame sender states
    typedef enum logic [1:0]
    {
        VCF_IDLE  = 2'b00,
        VCF_LOW   = 2'b01,
        VCF_HIGH  = 2'b10,
        VCF_RESET = 2'b11
    } vcf_state_t;
endpackage : vcf_pkg

// >>> hdl/vcf_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser for pins from outside the clock domain
module vcf_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    ////////////////////////////////////////////////////////////////////////////////
    // first stage is read only by the second
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : vcf_sync

// >>> hdl/vcf_top.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module vcf_top (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        cfg_sclk,
    input  wire logic        cfg_sen_n,
    input  wire logic        cfg_sdata,
    input  wire logic        reset_pin_n,
    output logic             section_serial_clock,
    output logic             section_serial_data,
    output logic             section_select,
    output logic [3:0]       digital_gain [8],
    output logic             out_twos_complement,
    output logic             out_msb_first,
    output logic             out_single_rate,
    output logic             frame_busy
);
    logic        sclk_s;
    logic        sel_s;
    logic        sdata_s;
    logic        rpin_low_s;
    logic        sclk_d;
    logic [4:0]  bit_cnt;
    logic [23:0] shift;
    logic [15:0] frame_low;
    logic [15:0] frame_mid;
    logic [7:0]  frame_high;
    logic        section_reset_hold;
    logic [15:0] gain_a;
    logic [15:0] gain_b;
    logic [15:0] out_format;
    logic [1:0]  rpin_cnt;
    logic        pin_reset;
    logic        pending;
    logic [3:0]  route_code [8];

    // reset image of the low word with its marker bits already forced
    localparam logic [15:0] LOW_DEFAULT = vcf_pkg::FRAME_LOW_RESET | vcf_pkg::FRAME_LOW_FORCE;

    // one address match per register, only on the edge that completes a word
    function automatic logic addr_hit(input logic done, input logic [7:0] a,
                                      input logic [7:0] target);
        return done && (a == target);
    endfunction : addr_hit

    ////////////////////////////////////////////////////////////////////////////////
    // the frame is 16 + 16 + 8 mirrored bits and the counters below are sized for
    // the package values; another choice there needs wider logic here
    if (vcf_pkg::FRAME_BITS != 40)
    begin : g_frame_bits_check
        $error("vcf_top: FRAME_BITS must equal the 40 mirrored bits");
    end
    if (vcf_pkg::WORD_BITS != 24)
    begin : g_word_bits_check
        $error("vcf_top: WORD_BITS must be 8 address plus 16 data bits");
    end
    if (vcf_pkg::RST_PULSE_CYC < 1 || vcf_pkg::RST_PULSE_CYC > 3)
    begin : g_pulse_check
        $error("vcf_top: RST_PULSE_CYC does not fit the 2-bit pulse counter");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pins from the host and the reset ball cross into clk
    vcf_sync #(.W(4)) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    ({cfg_sclk, !cfg_sen_n, cfg_sdata, !reset_pin_n}),
        .q    ({sclk_s, sel_s, sdata_s, rpin_low_s})
    );

    // host serial clock rising edge, taken on synchronised copies only
    // select and reset ball cross inverted, so the synchroniser's reset means idle
    wire         sclk_rise  = sclk_s && !sclk_d && sel_s;
    wire [23:0]  next_shift = {shift[22:0], sdata_s};
    // a word completes every 24 edges; in a burst each word carries its own address
    wire         word_done  = sclk_rise && (bit_cnt == 5'(vcf_pkg::WORD_BITS - 1));
    wire [7:0]   w_addr     = next_shift[23:16];
    wire [15:0]  w_data     = next_shift[15:0];

    // write strobes per register
    wire wr_soft  = addr_hit(word_done, w_addr, vcf_pkg::ADDR_SOFT_RESET);
    wire wr_hold  = addr_hit(word_done, w_addr, vcf_pkg::ADDR_SECTION_RST);
    wire wr_low   = addr_hit(word_done, w_addr, vcf_pkg::ADDR_FRAME_LOW);
    wire wr_mid   = addr_hit(word_done, w_addr, vcf_pkg::ADDR_FRAME_MID);
    wire wr_high  = addr_hit(word_done, w_addr, vcf_pkg::ADDR_FRAME_HIGH);
    wire wr_ga    = addr_hit(word_done, w_addr, vcf_pkg::ADDR_GAIN_A);
    wire wr_gb    = addr_hit(word_done, w_addr, vcf_pkg::ADDR_GAIN_B);
    wire wr_fmt   = addr_hit(word_done, w_addr, vcf_pkg::ADDR_OUT_FORMAT);

    wire soft_reset = wr_soft && w_data[vcf_pkg::SOFT_RESET_BIT];

    // forced marker bits are applied at store time so compare sees them too
    wire [15:0] low_new  = w_data | vcf_pkg::FRAME_LOW_FORCE;
    wire        chg_low  = wr_low  && (low_new != frame_low);
    wire        chg_mid  = wr_mid  && (w_data != frame_mid);
    wire        chg_high = wr_high && (w_data[7:0] != frame_high);
    wire        changed  = chg_low || chg_mid || chg_high;

    // section select follows the pin pulse or the holding bit
    assign section_select = pin_reset || section_reset_hold;
    wire   section_rst    = section_select || soft_reset;

    // control byte fields; markers are rebuilt here so no stored bit can clear them
    wire        section_powerdown_bit = frame_low[2];
    wire        filter_bandwidth_sel  = frame_low[3];
    wire        op_mode_lsb           = frame_low[4];
    wire        op_mode_msb           = frame_low[5];
    wire        amp_gain_lsb          = frame_low[6];
    wire        amp_gain_msb          = frame_low[7];
    wire [7:0]  control_byte          = {amp_gain_msb, amp_gain_lsb, op_mode_msb, op_mode_lsb,
                                         filter_bandwidth_sel, section_powerdown_bit,
                                         vcf_pkg::FRAME_LOW_FORCE[1:0]};

    // channel routing nibbles, channel 1 next to the control byte, lsb at the lower bit
    assign route_code[0] = frame_low[11:8];
    assign route_code[1] = frame_low[15:12];
    assign route_code[2] = frame_mid[3:0];
    assign route_code[3] = frame_mid[7:4];
    assign route_code[4] = frame_mid[11:8];
    assign route_code[5] = frame_mid[15:12];
    assign route_code[6] = frame_high[3:0];
    assign route_code[7] = frame_high[7:4];

    // frame: control byte, then channel codes 1..8 ascending; bit 0 leaves first
    wire [39:0] frame = {route_code[7], route_code[6], route_code[5], route_code[4],
                         route_code[3], route_code[2], route_code[1], route_code[0],
                         control_byte};

    ////////////////////////////////////////////////////////////////////////////////
    // host serial word shifter; deasserted select restarts the word
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sclk_d  <= 1'b0;
            bit_cnt <= '0;
            shift   <= '0;
        end
        else
        begin
            sclk_d <= sclk_s;
            // a deselect mid-word drops the partial word, so the next word starts aligned
            if (!sel_s)
                bit_cnt <= '0;
            else if (sclk_rise)
            begin
                shift   <= next_shift;
                bit_cnt <= word_done ? 5'd0 : bit_cnt + 5'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reset ball low longer than the minimum pulse raises section select
    // the pulse counter saturates, so a long hold of the ball never wraps
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rpin_cnt  <= '0;
            pin_reset <= 1'b0;
        end
        else
        begin
            if (!rpin_low_s)
                rpin_cnt <= '0;
            else if (rpin_cnt != 2'(vcf_pkg::RST_PULSE_CYC))
                rpin_cnt <= rpin_cnt + 2'd1;
            // a pulse shorter than one sample may be missed; the 10ns floor is below clk
            pin_reset <= rpin_low_s && (rpin_cnt >= 2'(vcf_pkg::RST_PULSE_CYC - 1));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // mirrored frame words
    // writes that land during a section reset are dropped: the reset wins
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            frame_low  <= LOW_DEFAULT;
            frame_mid  <= vcf_pkg::FRAME_MID_RESET;
            frame_high <= vcf_pkg::FRAME_HIGH_RESET;
        end
        else if (section_rst)
        begin
            frame_low  <= LOW_DEFAULT;
            frame_mid  <= vcf_pkg::FRAME_MID_RESET;
            frame_high <= vcf_pkg::FRAME_HIGH_RESET;
        end
        else
        begin
            if (wr_low)
                frame_low <= low_new;
            if (wr_mid)
                frame_mid <= w_data;
            if (wr_high)
                frame_high <= w_data[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // hold bit, digital gain and output format registers
    // soft reset clears these directly; the mirrors are cleared through section_rst
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            section_reset_hold <= 1'b0;
            gain_a             <= vcf_pkg::GAIN_RESET;
            gain_b             <= vcf_pkg::GAIN_RESET;
            out_format         <= vcf_pkg::FORMAT_RESET;
        end
        else if (soft_reset)
        begin
            section_reset_hold <= 1'b0;
            gain_a             <= vcf_pkg::GAIN_RESET;
            gain_b             <= vcf_pkg::GAIN_RESET;
            out_format         <= vcf_pkg::FORMAT_RESET;
        end
        else
        begin
            if (wr_hold)
                section_reset_hold <= w_data[vcf_pkg::SECTION_HOLD_BIT];
            if (wr_ga)
                gain_a <= w_data;
            if (wr_gb)
                gain_b <= w_data;
            if (wr_fmt)
                out_format <= w_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // a change during a frame waits and sends the newest contents afterwards
    // the set wins over the clear, so a change in the idle cycle in which a frame starts is not lost;
    // only one follow-up is queued, however many changes arrive meanwhile
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            pending <= 1'b0;
        else if (section_rst)
            pending <= 1'b0;
        else if (changed)
            pending <= 1'b1;
        else if (!frame_busy)
            pending <= 1'b0;
    end

    vcf_frame_tx #(
        .BITS (vcf_pkg::FRAME_BITS),
        .DIV  (vcf_pkg::OSC_DIV)
    ) u_tx (
        .clk   (clk),
        .rstn  (rstn),
        .hold  (section_rst),
        .start (pending),
        .frame (frame),
        .busy  (frame_busy),
        .sclk  (section_serial_clock),
        .sdata (section_serial_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // gain nibbles: 0x2A holds channels 4,3,2,1 from bit 0 up, 0x2B holds 8,7,6,5
    // codes beyond the gain range pass on unchanged; nothing clamps them here
    assign digital_gain[0] = gain_a[15:12];
    assign digital_gain[1] = gain_a[11:8];
    assign digital_gain[2] = gain_a[7:4];
    assign digital_gain[3] = gain_a[3:0];
    assign digital_gain[4] = gain_b[15:12];
    assign digital_gain[5] = gain_b[11:8];
    assign digital_gain[6] = gain_b[7:4];
    assign digital_gain[7] = gain_b[3:0];

    // output format bits; the fixed-one bits of this register are not checked
    assign out_twos_complement = out_format[vcf_pkg::FMT_BTC_BIT];
    assign out_msb_first       = out_format[vcf_pkg::FMT_MSB_FIRST_BIT];
    assign out_single_rate     = out_format[vcf_pkg::FMT_SDR_BIT];
endmodule : vcf_top

// >>> test/testbench.sv
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
// drives the register port through the host model and listens to the section link
module testbench;
    logic            clk;
    logic            rstn;
    logic            reset_pin_n;
    wire logic       cfg_sclk;
    wire logic       cfg_sen_n;
    wire logic       cfg_sdata;
    wire logic       sclk;
    wire logic       sdata;
    wire logic       section_select;
    wire logic       frame_busy;
    wire logic [3:0] gain [8];
    wire logic       twos;
    wire logic       msb;
    wire logic       sdr;
    int              err_total;
    int              check_count;
    int              frames;
    logic     [39:0] cap;
    logic     [39:0] last;

    vcf_host_model i_host (.clk(clk), .cfg_sclk(cfg_sclk), .cfg_sen_n(cfg_sen_n),
        .cfg_sdata(cfg_sdata));
    vcf_top i_dut (.clk(clk), .rstn(rstn), .cfg_sclk(cfg_sclk), .cfg_sen_n(cfg_sen_n),
        .cfg_sdata(cfg_sdata), .reset_pin_n(reset_pin_n), .section_serial_clock(sclk),
        .section_serial_data(sdata), .section_select(section_select), .digital_gain(gain),
        .out_twos_complement(twos), .out_msb_first(msb), .out_single_rate(sdr),
        .frame_busy(frame_busy));

    initial clk = 1'b0;
    always #20 clk = ~clk;
    // far receiver: bit 0 comes first, so shift in from the top
    always @(posedge sclk)
        cap <= {sdata, cap[39:1]};
    always @(negedge frame_busy)
    begin
        frames++;
        last = cap;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_host.send(1, {a, d, 48'h0});
    endtask : wr
    // a frame may already run when the write returns, so count from before it
    task automatic wr_frame(input logic [7:0] a, input logic [15:0] d, input logic [39:0] e);
        int f0;
        f0 = frames;
        wr(a, d);
        for (int i = 0; i < 2000 && frames == f0; i++)
            @(negedge clk);
        repeat (20) @(negedge clk);
        `CHK(frames - f0, 1)
        `CHK(last, e)
    endtask : wr_frame
    task automatic wr_none(input logic [7:0] a, input logic [15:0] d);
        int f0;
        f0 = frames;
        wr(a, d);
        repeat (300) @(negedge clk);
        `CHK(frames - f0, 0)
    endtask : wr_none
    // control byte: gain 3-i, mode i, bandwidth i[0], power-down i[1], markers 0
    function automatic logic [15:0] low(input int i);
        return {8'h00, 2'(3 - i), 2'(i), i[0], i[1], 2'b00};
    endfunction : low
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rstn = 1'b0;
        reset_pin_n = 1'b1;
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        `CHK({sclk, sdata, section_select, frame_busy}, 4'h0)
        `CHK({sdr, msb, twos, gain[0], gain[7]}, 11'h000)
        wr_frame(8'h17, 16'hA5C3, 40'h00_A5C3_0023);
        for (int i = 0; i < 4; i++)
            wr_frame(8'h16, low(i), {24'h00_A5C3, low(i) | 16'h0003});
        wr_none(8'h16, low(3));
        wr_none(8'h05, 16'hFFFF);
        i_host.send(3, {8'h16, 16'h00A8, 8'h17, 16'h1357, 8'h18, 16'h009B});
        repeat (400) @(negedge clk);
        `CHK(last, 40'h9B_1357_00AB)
        wr(8'h2A, 16'h1234);
        wr(8'h2B, 16'h5678);
        wr(8'h46, 16'h001C);
        repeat (4) @(negedge clk);
        for (int k = 0; k < 8; k++)
            `CHK(gain[k], 4'(k + 1))
        `CHK({sdr, msb, twos}, 3'h7)
        // holding section reset blocks frames until released
        wr(8'h03, 16'h0020);
        repeat (4) @(negedge clk);
        `CHK({section_select, frame_busy}, 2'h2)
        wr(8'h03, 16'h0000);
        repeat (4) @(negedge clk);
        `CHK(section_select, 1'b0)
        wr_frame(8'h18, 16'h0011, 40'h11_0000_0023);
        // short low pulse on the reset ball
        reset_pin_n = 1'b0;
        repeat (3) @(negedge clk);
        reset_pin_n = 1'b1;
        for (int i = 0; i < 8 && section_select !== 1'b1; i++)
            @(negedge clk);
        `CHK(section_select, 1'b1)
        repeat (10) @(negedge clk);
        wr_frame(8'h17, 16'h0001, 40'h00_0001_0023);
        wr_none(8'h00, 16'h0001);
        `CHK({sdr, msb, twos, gain[0], gain[7]}, 11'h000)
        wr_frame(8'h17, 16'h0001, 40'h00_0001_0023);
        give_verdict();
    end
    // cut a hang short well past the expected run length
    initial
    begin
        #2_000_000;
        err_total++;
        give_verdict();
    end
endmodule : testbench

// >>> test/vcf_host_model.sv
`timescale 1ns/1ns
// host side of the serial register port; its clock stands still between select windows
module vcf_host_model (
    input  wire logic clk,
    output logic      cfg_sclk,
    output logic      cfg_sen_n,
    output logic      cfg_sdata
);
    initial
    begin
        cfg_sclk  = 1'b0;
        cfg_sen_n = 1'b1;
        cfg_sdata = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////
    // n words from the top of w in one select window, 320 ns per bit, msb first
    task automatic send(input int n, input logic [71:0] w);
        cfg_sen_n = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 71; i > 71 - 24 * n; i--)
        begin
            cfg_sdata = w[i];
            repeat (4) @(negedge clk);
            cfg_sclk = 1'b1;
            repeat (4) @(negedge clk);
            cfg_sclk = 1'b0;
        end
        repeat (4) @(negedge clk);
        cfg_sen_n = 1'b1;
        // released line flips so a stale bit is never read as valid
        cfg_sdata = ~cfg_sdata;
        // select stays high a while so back-to-back words see a deselect
        repeat (4) @(negedge clk);
    endtask : send
endmodule : vcf_host_model

// >>> test/vcf_top_sva.sv
`timescale 1ns/1ns
// watches the section link and select at the top module's pins
module vcf_top_sva (
    input wire logic clk,
    input wire logic rstn,
    input wire logic reset_pin_n,
    input wire logic section_serial_clock,
    input wire logic section_serial_data,
    input wire logic section_select,
    input wire logic frame_busy
);
    logic       [9:0] busy_cnt;
    // busy stretch length; a counter avoids a 160-deep repetition
    wire logic  [9:0] next_busy_cnt = frame_busy ? busy_cnt + 10'h001 : 10'h000;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            busy_cnt <= 10'h000;
        else
            busy_cnt <= next_busy_cnt;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_link_idle: assert property (!frame_busy && !$past(frame_busy)
        |-> !section_serial_clock && !section_serial_data) else $error("link not idle");
    // every frame, a queued follow-up too, drops busy for a cycle before it starts
    a_frame_len: assert property ($fell(frame_busy) && !section_select
        |-> busy_cnt == 10'h0A0) else $error("frame length");
    a_clk_high: assert property ($rose(section_serial_clock)
        |-> section_serial_clock ##1 section_serial_clock ##1 !section_serial_clock)
        else $error("clock high time");
    a_clk_gated: assert property (section_serial_clock |-> frame_busy)
        else $error("clock outside frame");
    a_data_steady: assert property ($rose(section_serial_clock)
        |-> $stable(section_serial_data) ##1 $stable(section_serial_data)) else $error("data moved");
    a_frame_markers: assert property ($rose(frame_busy)
        |-> section_serial_data ##4 section_serial_data) else $error("marker bits");
    a_first_edge: assert property ($rose(frame_busy)
        |-> !section_serial_clock [*2] ##1 section_serial_clock) else $error("first edge");
    a_hold_quiet: assert property (section_select [*3] |-> !frame_busy)
        else $error("frame during section reset");
    a_pin_select: assert property (!reset_pin_n [*2] |-> ##[0:5] section_select)
        else $error("pin reset missed");
endmodule : vcf_top_sva
bind vcf_top vcf_top_sva i_sva (.clk(clk), .rstn(rstn), .reset_pin_n(reset_pin_n),
    .section_serial_clock(section_serial_clock), .section_serial_data(section_serial_data),
    .section_select(section_select), .frame_busy(frame_busy));
